/* File: logic/uab_baud_counter.sv */
// Free-running baud measurement counter with wrap indication
module uab_baud_counter #(
    parameter int CNT_W = 16
) (
    input  wire logic             clk,
    input  wire logic             nrst,
    input  wire logic             clr,
    input  wire logic             en,
    output logic      [CNT_W-1:0] count,
    output logic                  wrap
);
    logic [CNT_W-1:0] count_q;

    // ======================================================================
    // Counter wraps through zero and keeps running
    always_ff @(posedge clk) begin
        if (!nrst || clr) begin
            count_q <= '0;
        end else if (en) begin
            count_q <= count_q + 1'b1;
        end
    end

    assign count = count_q;
    assign wrap  = en & (&count_q);
endmodule

/* File: logic/uab_params.svh */
// Offsets, field positions, reset values and counts for the autobaud/wake block
`ifndef UAB_PARAMS_SVH
`define UAB_PARAMS_SVH

// ==========================================================================
// Register byte offsets (AHB-Lite, one word each)
`define UAB_OFF_CTRL      8'h00
`define UAB_OFF_RXDATA    8'h04
`define UAB_OFF_DIVISOR   8'h08
`define UAB_OFF_STATUS    8'h0C
`define UAB_OFF_MASK      8'h10

// ==========================================================================
// Control register fields
`define UAB_CTRL_AUTOBAUD_DETECT_ENABLE    0
`define UAB_CTRL_WUE      1
`define UAB_CTRL_OVF      2
`define UAB_CTRL_RXIDLE   3
`define UAB_CTRL_ASYNC    4

// ==========================================================================
// Interrupt status fields
`define UAB_IRQ_ABDONE    0
`define UAB_IRQ_WAKE      1
`define UAB_IRQ_OVF       2
`define UAB_IRQ_W         3

// ==========================================================================
// Reset values and counts
`define UAB_RST_ASYNC     1'b1
`define UAB_RST_DIVISOR   16'h0000
`define UAB_RST_MASK      3'h0
`define UAB_FIFTH_EDGE    3'h4
`define UAB_SYNC_IDLE     1'b1

`endif

/* File: logic/uab_pkg.sv */
// Types shared by the autobaud/wake block
package uab_pkg;

    // ======================================================================
    // Auto-baud measurement states
    typedef enum logic [1:0] {
        AB_IDLE  = 2'b00,
        AB_ARM   = 2'b01,
        AB_COUNT = 2'b10
    } uab_ab_state_type;

    // ======================================================================
    // Wake-on-break states
    typedef enum logic [1:0] {
        WK_OFF   = 2'b00,
        WK_WATCH = 2'b01,
        WK_LOW   = 2'b10
    } uab_wk_state_type;

endpackage

/* File: logic/uab_rx_sync.sv */
// Two-flop synchroniser and edge detector for the receive data line
`include "uab_params.svh"
module uab_rx_sync (
    input  wire logic clk,
    input  wire logic nrst,
    input  wire logic rxPin,
    output logic      rxLevel,
    output logic      rxRise,
    output logic      rxFall
);
    logic meta_q;
    logic sync_q;
    logic prev_q;

    // ======================================================================
    // Synchroniser; idle line is high
    always_ff @(posedge clk) begin
        if (!nrst) begin
            meta_q <= `UAB_SYNC_IDLE;
            sync_q <= `UAB_SYNC_IDLE;
            prev_q <= `UAB_SYNC_IDLE;
        end else begin
            meta_q <= rxPin;
            sync_q <= meta_q;
            prev_q <= sync_q;
        end
    end

    assign rxLevel = sync_q;
    assign rxRise  = sync_q & ~prev_q;
    assign rxFall  = ~sync_q & prev_q;
endmodule

/* File: logic/uab_top.sv */
// Auto-baud overflow and wake-on-break helper with AHB-Lite registers
//
// The implementer's own choices: the AHB-Lite interface to the registers and the address map.
`include "uab_params.svh"

// Behaviour
// - Set overflow flag if baud counter wraps before fifth rising edge.
// - Overflow means count passed the 16-bit divisor pair maximum.
// - After overflow the counter keeps counting until the fifth edge.
// - Fifth rising edge sets receive interrupt flag, clears auto-baud enable.
// - Reading receive data register clears the receive interrupt flag.
// - Software clears the overflow flag by writing it directly.
// - Overflow flag stays set while auto-baud enable is still set.
// - In sleep the baud generator idles and reception is disabled.
// - Wake-up on line activity only in asynchronous mode.
// - Wake enable suppresses normal reception; block idles watching the line.
// - A falling edge on the receive line is the wake-up event.
// - Wake-up event raises the receive interrupt flag.
// - Rising edge ending the break clears wake enable in hardware.
// - Any low period length qualifies as wake-up; no timeout.
// - Non-zero character wakes at first low; rest arrives as fragment.
module uab_top
    import uab_pkg::*;
#(
    parameter int CNT_W = 16
) (
    input  wire logic        clk,
    input  wire logic        nrst,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic             hresp,
    output logic      [31:0] hrdata,
    input  wire logic        rxPin,
    input  wire logic        sleepMode,
    input  wire logic [7:0]  rxByte,
    input  wire logic        rxByteValid,
    input  wire logic        rxIdle,
    output logic             rxEnable,
    output logic             wakeReq,
    output logic             irq
);
    // ======================================================================
    // Declarations
    logic                 hreadyout_q;
    logic                 hresp_q;
    logic [31:0]          hrdata_q;
    logic                 wrPend_q;
    logic [7:0]           wrAddr_q;
    logic                 autobaud_detect_enable_q;
    logic                 wakeEn_q;
    logic                 ovf_q;
    logic                 async_q;
    logic                 rif_q;
    logic [7:0]           rxData_q;
    logic [CNT_W-1:0]     divisor_q;
    logic [`UAB_IRQ_W-1:0] stat_q;
    logic [`UAB_IRQ_W-1:0] mask_q;
    logic                 irq_q;
    logic                 rxEnable_q;
    logic                 wakeReq_q;
    logic [2:0]           edgeCnt_q;
    uab_ab_state_type     abState_q;
    uab_ab_state_type     abState_d;
    uab_wk_state_type     wkState_q;
    uab_wk_state_type     wkState_d;
    logic                 rxRise;
    logic                 rxFall;
    logic [CNT_W-1:0]     abCount;
    logic                 cntWrap;

    // ======================================================================
    // Receive line synchroniser and measurement counter
    uab_rx_sync u_sync (
        .clk     (clk),
        .nrst    (nrst),
        .rxPin   (rxPin),
        .rxLevel (),
        .rxRise  (rxRise),
        .rxFall  (rxFall)
    );

    wire cntEn  = (abState_q == AB_COUNT) & ~sleepMode;
    wire cntClr = (abState_q != AB_COUNT);

    uab_baud_counter #(
        .CNT_W (CNT_W)
    ) u_cnt (
        .clk   (clk),
        .nrst  (nrst),
        .clr   (cntClr),
        .en    (cntEn),
        .count (abCount),
        .wrap  (cntWrap)
    );

    // ======================================================================
    // AHB-Lite decode; zero wait states, always OKAY
    wire       addrPhase = hsel & htrans[1] & hready;
    wire       rdHit     = addrPhase & ~hwrite;
    wire [7:0] rdAddr    = haddr[7:0];
    wire       wrCtrl    = wrPend_q & (wrAddr_q == `UAB_OFF_CTRL);
    wire       wrDiv     = wrPend_q & (wrAddr_q == `UAB_OFF_DIVISOR);
    wire       wrStat    = wrPend_q & (wrAddr_q == `UAB_OFF_STATUS);
    wire       wrMask    = wrPend_q & (wrAddr_q == `UAB_OFF_MASK);
    wire       rdRx      = rdHit & (rdAddr == `UAB_OFF_RXDATA);

    wire [31:0] ctrlView = {26'h000_0000, rif_q, async_q, rxIdle, ovf_q,
                            wakeEn_q, autobaud_detect_enable_q};
    wire [31:0] rdMux =
        (rdAddr == `UAB_OFF_CTRL)    ? ctrlView :
        (rdAddr == `UAB_OFF_RXDATA)  ? {24'h00_0000, rxData_q} :
        (rdAddr == `UAB_OFF_DIVISOR) ? {{(32-CNT_W){1'b0}}, divisor_q} :
        (rdAddr == `UAB_OFF_STATUS)  ? {29'h000_0000, stat_q} :
        (rdAddr == `UAB_OFF_MASK)    ? {29'h000_0000, mask_q} :
        32'h0000_0000;

    always_ff @(posedge clk) begin
        if (!nrst) begin
            hreadyout_q <= 1'b1;
            hresp_q     <= 1'b0;
            hrdata_q    <= 32'h0000_0000;
            wrPend_q    <= 1'b0;
            wrAddr_q    <= 8'h00;
        end else begin
            hreadyout_q <= 1'b1;
            hresp_q     <= 1'b0;
            hrdata_q    <= rdHit ? rdMux : hrdata_q;
            wrPend_q    <= addrPhase & hwrite;
            wrAddr_q    <= addrPhase ? haddr[7:0] : wrAddr_q;
        end
    end

    // ======================================================================
    // Auto-baud measurement
    // fifth rising edge ends measurement
    wire abDone = (abState_q == AB_COUNT) & rxRise
                  & (edgeCnt_q == `UAB_FIFTH_EDGE);
    // wrap before fifth edge flags overflow
    wire ovfSet = (abState_q == AB_COUNT) & cntWrap;

    always_comb begin
        abState_d = abState_q;
        case (abState_q)
            AB_IDLE: begin
                if (autobaud_detect_enable_q && !sleepMode)
                    abState_d = AB_ARM;
            end
            AB_ARM: begin
                if (!autobaud_detect_enable_q)
                    abState_d = AB_IDLE;
                else if (rxRise)
                    abState_d = AB_COUNT;
            end
            AB_COUNT: begin
                // count runs past overflow until fifth edge
                if (!autobaud_detect_enable_q || abDone)
                    abState_d = AB_IDLE;
            end
            default: abState_d = AB_IDLE;
        endcase
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            abState_q <= AB_IDLE;
            edgeCnt_q <= 3'h0;
        end else begin
            abState_q <= abState_d;
            if (abState_q != AB_COUNT)
                edgeCnt_q <= 3'h1;
            else if (rxRise)
                edgeCnt_q <= edgeCnt_q + 3'h1;
        end
    end

    // ======================================================================
    // Wake on break
    // falling edge is the wake event
    wire wakeFall = (wkState_q == WK_WATCH) & rxFall & wakeEn_q & async_q;
    // closing rising edge ends the break
    wire wakeDone = (wkState_q == WK_LOW) & rxRise;

    always_comb begin
        wkState_d = wkState_q;
        case (wkState_q)
            WK_OFF: begin
                if (wakeEn_q && async_q)
                    wkState_d = WK_WATCH;
            end
            WK_WATCH: begin
                if (!wakeEn_q || !async_q)
                    wkState_d = WK_OFF;
                else if (rxFall)
                    wkState_d = WK_LOW;
            end
            WK_LOW: begin
                // no timeout on the low period
                if (!wakeEn_q || wakeDone)
                    wkState_d = WK_OFF;
            end
            default: wkState_d = WK_OFF;
        endcase
    end

    always_ff @(posedge clk) begin
        if (!nrst)
            wkState_q <= WK_OFF;
        else
            wkState_q <= wkState_d;
    end

    // ======================================================================
    // Control bits
    // software clear; refused while enable still set
    wire ovfClr  = wrCtrl & ~hwdata[`UAB_CTRL_OVF] & ~autobaud_detect_enable_q;
    // receive flag from wake, auto-baud and received bytes
    wire setRif  = abDone | wakeFall | (rxByteValid & rxEnable_q);

    always_ff @(posedge clk) begin
        if (!nrst) begin
            autobaud_detect_enable_q  <= 1'b0;
            wakeEn_q <= 1'b0;
            ovf_q    <= 1'b0;
            async_q  <= `UAB_RST_ASYNC;
            rif_q    <= 1'b0;
        end else begin
            if (abDone)
                autobaud_detect_enable_q <= 1'b0;
            else if (wrCtrl)
                autobaud_detect_enable_q <= hwdata[`UAB_CTRL_AUTOBAUD_DETECT_ENABLE];
            if (wakeDone)
                wakeEn_q <= 1'b0;
            else if (wrCtrl)
                wakeEn_q <= hwdata[`UAB_CTRL_WUE];
            // Set wins over a simultaneous clear
            ovf_q   <= ovfSet | (ovf_q & ~ovfClr);
            async_q <= wrCtrl ? hwdata[`UAB_CTRL_ASYNC] : async_q;
            rif_q   <= setRif | (rif_q & ~rdRx);
        end
    end

    // ======================================================================
    // Data, divisor and outputs
    // reception off in sleep, wake watch or measurement
    wire rxEnable_d = ~sleepMode & ~wakeEn_q & ~autobaud_detect_enable_q;

    always_ff @(posedge clk) begin
        if (!nrst) begin
            rxData_q   <= 8'h00;
            divisor_q  <= CNT_W'(`UAB_RST_DIVISOR);
            rxEnable_q <= 1'b0;
            wakeReq_q  <= 1'b0;
        end else begin
            // fragments after a wake still land here
            if (rxByteValid && rxEnable_q)
                rxData_q <= rxByte;
            // result is the raw CNT_W-bit measurement
            if (abDone)
                divisor_q <= abCount;
            else if (wrDiv)
                divisor_q <= hwdata[CNT_W-1:0];
            rxEnable_q <= rxEnable_d;
            wakeReq_q  <= wakeFall;
        end
    end

    // ======================================================================
    // Interrupt status, write one to clear; events win over clears
    wire [`UAB_IRQ_W-1:0] evt    = {ovfSet, wakeFall, abDone};
    wire [`UAB_IRQ_W-1:0] w1c    = wrStat ? hwdata[`UAB_IRQ_W-1:0]
                                          : {`UAB_IRQ_W{1'b0}};

    always_ff @(posedge clk) begin
        if (!nrst) begin
            stat_q <= {`UAB_IRQ_W{1'b0}};
            mask_q <= `UAB_RST_MASK;
            irq_q  <= 1'b0;
        end else begin
            stat_q <= evt | (stat_q & ~w1c);
            mask_q <= wrMask ? hwdata[`UAB_IRQ_W-1:0] : mask_q;
            irq_q  <= |(stat_q & mask_q);
        end
    end

    assign hreadyout = hreadyout_q;
    assign hresp     = hresp_q;
    assign hrdata    = hrdata_q;
    assign rxEnable  = rxEnable_q;
    assign wakeReq   = wakeReq_q;
    assign irq       = irq_q;

    // ======================================================================
    // Checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);
    sequence wakeArmedFall;
        (wkState_q == WK_WATCH) && rxFall && wakeEn_q && async_q;
    endsequence
    sequence breakEnd;
        (wkState_q == WK_LOW) && rxRise;
    endsequence

    ovf_on_wrap_a: assert property (
        ovfSet |=> ovf_q && stat_q[`UAB_IRQ_OVF])
        else $error("overflow flag not set after counter wrap");

    wrap_at_max_a: assert property (
        cntWrap |-> (abCount == {CNT_W{1'b1}}) ##1 (abCount == '0
            || abState_q != AB_COUNT))
        else $error("counter wrapped away from its maximum");

    count_after_ovf_a: assert property (
        ovf_q && cntEn && !abDone |=>
            abCount == CNT_W'($past(abCount) + 1'b1))
        else $error("counter stopped after overflow");

    fifth_edge_done_a: assert property (
        abDone |=> rif_q && !autobaud_detect_enable_q ##1 abState_q == AB_IDLE)
        else $error("fifth edge did not finish measurement");

    rif_read_clear_a: assert property (
        rdRx && !setRif |=> !rif_q)
        else $error("receive data read left flag set");

    ovf_sw_clear_a: assert property (
        ovfClr && !ovfSet |=> !ovf_q)
        else $error("software clear of overflow ignored");

    ovf_hold_en_a: assert property (
        ovf_q && autobaud_detect_enable_q |=> ovf_q)
        else $error("overflow cleared while enable still set");

    sleep_idle_a: assert property (
        sleepMode |-> !cntEn ##1 !rxEnable_q)
        else $error("baud logic active in sleep");

    async_only_a: assert property (
        !async_q && wkState_q == WK_OFF |=> wkState_q == WK_OFF)
        else $error("wake armed outside asynchronous mode");

    rx_suppress_a: assert property (
        wakeEn_q [*2] |-> !rxEnable_q)
        else $error("reception enabled during wake watch");

    wake_event_a: assert property (
        wakeArmedFall |=> rif_q && wakeReq_q && wkState_q == WK_LOW)
        else $error("wake event missed falling edge");

    wue_clear_a: assert property (
        breakEnd |=> !wakeEn_q ##1 wkState_q == WK_OFF)
        else $error("wake enable not cleared at break end");

    reset_zero_a: assert property (
        $rose(nrst) |-> !autobaud_detect_enable_q && !wakeEn_q && !ovf_q)
        else $error("control bits not zero after reset");
endmodule

/* File: tb/tb_uart_autobaud_overflow_and_break_wakeup.sv */
// Self-checking bench for the auto-baud and wake-on-break helper
`include "uab_params.svh"
module tb_uart_autobaud_overflow_and_break_wakeup;
    timeunit 1ns;
    timeprecision 1ns;

    typedef struct {
        logic        wr;
        logic [7:0]  addr;
        logic [31:0] data;
    } uab_row_type;

    logic        clk;
    logic        nrst;
    logic        hsel;
    logic [31:0] haddr;
    logic [1:0]  htrans;
    logic        hwrite;
    logic [2:0]  hsize;
    logic [31:0] hwdata;
    wire logic   hready;
    logic        hreadyout;
    logic        hresp;
    logic [31:0] hrdata;
    logic        rxPin;
    logic        sleepMode;
    logic [7:0]  rxByte;
    logic        rxByteValid;
    logic        rxIdle;
    logic        rxEnable;
    logic        wakeReq;
    logic        irq;
    logic [31:0] rdata;
    int          failures;
    int          testsRun;
    int          wakeCount;
    int          base;
    int          n;

    // Reset contents, unmapped place, read-write mask and divisor
    uab_row_type rows [12] = '{
        '{1'b0, `UAB_OFF_CTRL,    32'h0000_0018},
        '{1'b0, `UAB_OFF_RXDATA,  32'h0000_0000},
        '{1'b0, `UAB_OFF_DIVISOR, 32'h0000_0000},
        '{1'b0, `UAB_OFF_STATUS,  32'h0000_0000},
        '{1'b0, `UAB_OFF_MASK,    32'h0000_0000},
        '{1'b0, 8'h14,            32'h0000_0000},
        '{1'b1, `UAB_OFF_MASK,    32'h0000_0007},
        '{1'b0, `UAB_OFF_MASK,    32'h0000_0007},
        '{1'b1, `UAB_OFF_DIVISOR, 32'h0000_00C3},
        '{1'b0, `UAB_OFF_DIVISOR, 32'h0000_00C3},
        '{1'b1, 8'h14,            32'hFFFF_FFFF},
        '{1'b0, 8'h14,            32'h0000_0000}
    };

    assign hready = hreadyout;

    uab_top #(.CNT_W(8)) dut_u (
        .clk(clk), .nrst(nrst), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
        .hresp(hresp), .hrdata(hrdata), .rxPin(rxPin),
        .sleepMode(sleepMode), .rxByte(rxByte),
        .rxByteValid(rxByteValid), .rxIdle(rxIdle),
        .rxEnable(rxEnable), .wakeReq(wakeReq), .irq(irq)
    );

    uab_remote_node remote_u (
        .clk(clk),
        .rxPin(rxPin)
    );

    // ======================================================================
    // Helpers
    task automatic results;
        $display("comparisons %0d, mismatches %0d", testsRun, failures);
        if (failures == 0 && testsRun > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        testsRun++;
        if (seen !== exp) begin
            failures++;
            $display("wrong value at %0t: seen %h expected %h",
                     $time, seen, exp);
        end
    endtask

    // Address phase held until ready, then data phase until ready
    task automatic busXfer(input logic wr, input logic [7:0] a,
                           input logic [31:0] wd, output logic [31:0] rd);
        int k;
        k = 0;
        @(posedge clk);
        hsel   <= 1'b1;
        htrans <= 2'b10;
        haddr  <= {24'h00_0000, a};
        hwrite <= wr;
        do begin
            @(posedge clk);
            k++;
        end while (hreadyout !== 1'b1 && k < 50);
        hsel   <= 1'b0;
        htrans <= 2'b00;
        hwdata <= wd;
        do begin
            @(posedge clk);
            k++;
        end while (hreadyout !== 1'b1 && k < 100);
        rd = hrdata;
        if (k >= 100) begin
            failures++;
            results();
        end
    endtask

    task automatic wrReg(input logic [7:0] a, input logic [31:0] d);
        busXfer(1'b1, a, d, rdata);
    endtask

    task automatic readChk(input logic [7:0] a, input logic [31:0] exp);
        busXfer(1'b0, a, 32'h0000_0000, rdata);
        check(rdata, exp);
    endtask

    task automatic waitIrq(input logic lvl);
        int k;
        k = 0;
        while (irq !== lvl && k < 3000) begin
            @(posedge clk);
            k++;
        end
        check({31'h0, irq}, {31'h0, lvl});
        if (k >= 3000) begin
            results();
        end
    endtask

    task automatic pulseByte(input logic [7:0] b);
        @(posedge clk);
        rxByte      <= b;
        rxByteValid <= 1'b1;
        @(posedge clk);
        rxByteValid <= 1'b0;
    endtask

    // ======================================================================
    // Clock and wake pulse counter
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    always @(posedge clk) begin
        if (wakeReq === 1'b1) begin
            wakeCount <= wakeCount + 1;
        end
    end

    // ======================================================================
    // Main sequence
    initial begin
        nrst = 1'b0; hsel = 1'b0; haddr = 32'h0000_0000; htrans = 2'b00;
        hwrite = 1'b0; hsize = 3'b010; hwdata = 32'h0000_0000;
        sleepMode = 1'b0; rxByte = 8'h00; rxByteValid = 1'b0;
        rxIdle = 1'b1; failures = 0; testsRun = 0; wakeCount = 0;
        repeat (4) @(posedge clk);
        nrst <= 1'b1;
        repeat (3) @(posedge clk);
        check({30'h0, hreadyout, hresp}, 32'h0000_0002);
        check({31'h0, rxEnable}, 32'h0000_0001);
        foreach (rows[i]) begin
            if (rows[i].wr) begin
                wrReg(rows[i].addr, rows[i].data);
            end else begin
                busXfer(1'b0, rows[i].addr, 32'h0000_0000, rdata);
                check(rdata, rows[i].data);
            end
        end
        // Bytes are taken only while reception is allowed
        pulseByte(8'hA5);
        readChk(`UAB_OFF_RXDATA, 32'h0000_00A5);
        sleepMode <= 1'b1;
        repeat (3) @(posedge clk);
        check({31'h0, rxEnable}, 32'h0000_0000);
        pulseByte(8'h3C);
        readChk(`UAB_OFF_RXDATA, 32'h0000_00A5);
        sleepMode <= 1'b0;
        // Auto-baud on a 0x55 character, 16 clocks a bit
        wrReg(`UAB_OFF_CTRL, 32'h0000_0011);
        remote_u.sendChar(8'h55, 16);
        waitIrq(1'b1);
        readChk(`UAB_OFF_CTRL, 32'h0000_0038);
        readChk(`UAB_OFF_STATUS, 32'h0000_0001);
        busXfer(1'b0, `UAB_OFF_DIVISOR, 32'h0000_0000, rdata);
        check({31'h0, (rdata >= 127 && rdata <= 129)}, 32'h1);
        readChk(`UAB_OFF_RXDATA, 32'h0000_00A5);
        readChk(`UAB_OFF_CTRL, 32'h0000_0018);
        wrReg(`UAB_OFF_STATUS, 32'h0000_0001);
        waitIrq(1'b0);
        // Slow edges make the 8-bit counter wrap before the fifth
        wrReg(`UAB_OFF_CTRL, 32'h0000_0011);
        remote_u.sendEdges(4, 25, 25);
        readChk(`UAB_OFF_CTRL, 32'h0000_0019);
        // Sleep freezes the count, so no wrap yet
        sleepMode <= 1'b1;
        repeat (100) @(posedge clk);
        sleepMode <= 1'b0;
        readChk(`UAB_OFF_CTRL, 32'h0000_0019);
        repeat (120) @(posedge clk);
        readChk(`UAB_OFF_CTRL, 32'h0000_001D);
        readChk(`UAB_OFF_STATUS, 32'h0000_0004);
        wrReg(`UAB_OFF_CTRL, 32'h0000_0011);
        readChk(`UAB_OFF_CTRL, 32'h0000_001D);
        remote_u.sendEdges(1, 25, 25);
        readChk(`UAB_OFF_CTRL, 32'h0000_003C);
        readChk(`UAB_OFF_STATUS, 32'h0000_0005);
        wrReg(`UAB_OFF_CTRL, 32'h0000_0010);
        readChk(`UAB_OFF_CTRL, 32'h0000_0038);
        wrReg(`UAB_OFF_STATUS, 32'h0000_0007);
        waitIrq(1'b0);
        readChk(`UAB_OFF_RXDATA, 32'h0000_00A5);
        // Wake on a long break, wake event masked at first
        wrReg(`UAB_OFF_MASK, 32'h0000_0005);
        base = wakeCount;
        wrReg(`UAB_OFF_CTRL, 32'h0000_0012);
        repeat (3) @(posedge clk);
        check({31'h0, rxEnable}, 32'h0000_0000);
        fork
            remote_u.sendBreak(16, 13);
            begin
                n = 0;
                while (wakeReq !== 1'b1 && n < 8) begin
                    @(posedge clk);
                    n++;
                end
                check({31'h0, wakeReq}, 32'h0000_0001);
                readChk(`UAB_OFF_CTRL, 32'h0000_003A);
            end
        join
        readChk(`UAB_OFF_CTRL, 32'h0000_0038);
        check(32'(wakeCount - base), 32'h0000_0001);
        readChk(`UAB_OFF_STATUS, 32'h0000_0002);
        check({31'h0, irq}, 32'h0000_0000);
        wrReg(`UAB_OFF_MASK, 32'h0000_0007);
        waitIrq(1'b1);
        wrReg(`UAB_OFF_STATUS, 32'h0000_0002);
        waitIrq(1'b0);
        check({31'h0, rxEnable}, 32'h0000_0001);
        // No wake watch outside asynchronous mode
        base = wakeCount;
        wrReg(`UAB_OFF_CTRL, 32'h0000_0002);
        remote_u.sendBreak(16, 13);
        check(32'(wakeCount - base), 32'h0000_0000);
        readChk(`UAB_OFF_STATUS, 32'h0000_0000);
        wrReg(`UAB_OFF_CTRL, 32'h0000_0010);
        // Non-zero character: start bit alone is the wake event
        base = wakeCount;
        wrReg(`UAB_OFF_CTRL, 32'h0000_0012);
        remote_u.sendChar(8'h01, 16);
        check(32'(wakeCount - base), 32'h0000_0001);
        readChk(`UAB_OFF_CTRL, 32'h0000_0038);
        wrReg(`UAB_OFF_STATUS, 32'h0000_0002);
        // Second reset with both enables set
        wrReg(`UAB_OFF_CTRL, 32'h0000_0013);
        nrst <= 1'b0;
        repeat (2) @(posedge clk);
        nrst <= 1'b1;
        readChk(`UAB_OFF_CTRL, 32'h0000_0018);
        rxIdle <= 1'b0;
        readChk(`UAB_OFF_CTRL, 32'h0000_0010);
        rxIdle <= 1'b1;
        results();
    end
endmodule

/* File: tb/uab_remote_node.sv */
// Remote serial node model that drives the receive data line
module uab_remote_node (
    input  wire logic clk,
    output logic      rxPin
);
    timeunit 1ns;
    timeprecision 1ns;

    // ======================================================================
    // Line control
    // Line rests high when no frame is sent
    initial rxPin = 1'b1;

    task automatic hold(input logic lvl, input int clks);
        @(posedge clk);
        rxPin <= lvl;
        repeat (clks - 1) @(posedge clk);
    endtask

    // ======================================================================
    // Frames
    // all-zero wake break
    task automatic sendBreak(input int bitClks, input int bits);
        hold(1'b0, bitClks * bits);
        hold(1'b1, bitClks * 4);
    endtask

    // Start bit, eight data bits first bit lowest, then idle
    task automatic sendChar(input logic [7:0] data, input int bitClks);
        hold(1'b0, bitClks);
        for (int i = 0; i < 8; i++) begin
            hold(data[i], bitClks);
        end
        hold(1'b1, bitClks * 2);
    endtask

    // Each pulse gives one rising edge
    task automatic sendEdges(input int n, input int lowClks,
                             input int highClks);
        for (int i = 0; i < n; i++) begin
            hold(1'b0, lowClks);
            hold(1'b1, highClks);
        end
    endtask
endmodule
